/* File: hdl/mlsau_core.sv */
/*
 masked load/store alias unit: masked loads and stores, forwarding decisions,
 4k alias detection with penalty and event count, page-cross handling, miss fill.
 assumes the core issues one load at a time and the cache acks fills and commits.
*/
`timescale 1ns/1ps
module mlsau_core (
    input  wire logic         i_clock,
    input  wire logic         i_rst_n,
    // store side
    input  wire logic         i_st_valid,
    input  wire logic [47:0]  i_st_addr,
    input  wire logic [255:0] i_st_data,
    input  wire logic [255:0] i_st_mask,
    input  wire logic         i_st_masked,
    input  wire logic         i_st_mask_known,
    input  wire logic         i_st_elem64,
    input  wire logic         i_st_wide,
    input  wire logic         i_st_commit,
    // load side
    input  wire logic         i_ld_valid,
    input  wire logic [47:0]  i_ld_addr,
    input  wire logic [255:0] i_ld_mask,
    input  wire logic         i_ld_masked,
    input  wire logic         i_ld_elem64,
    input  wire logic         i_ld_wide,
    input  wire logic         i_ld_illegal,
    input  wire logic [31:0]  i_ld_illegal_bytes,
    input  wire logic         i_ld_retire,
    input  wire logic         i_disamb_clear,
    // level_one_data_cache side
    input  wire logic         i_cache_hit,
    input  wire logic [255:0] i_cache_data,
    input  wire logic         i_fill_done,
    output logic              o_fill_req,
    output logic [47:0]       o_fill_addr,
    output logic              o_st_write,
    output logic [47:0]       o_st_write_addr,
    output logic [255:0]      o_st_write_data,
    output logic [31:0]       o_st_write_be,
    output logic              o_st_busy,
    // answers to the core
    output logic              o_ld_done,
    output logic [255:0]      o_ld_data,
    output logic              o_ld_fault,
    output logic              o_ld_forwarded,
    output logic              o_ld_busy,
    output logic              o_alias_flag,
    output logic [31:0]       o_alias_blocked_load_event
);
    ////////////////////////////////////////////////////////////////////////////
    logic [31:0]  st_be;
    logic         st_all1;
    logic         st_all0;
    logic [31:0]  ld_be;
    logic         ld_all1;
    logic         ld_all0;

    mlsau_mask_decode u_st_dec (
        .i_mask     (i_st_mask),
        .i_elem64   (i_st_elem64),
        .i_wide     (i_st_wide),
        .o_byte_en  (st_be),
        .o_all_ones (st_all1),
        .o_all_zero (st_all0)
    );
    mlsau_mask_decode u_ld_dec (
        .i_mask     (i_ld_mask),
        .i_elem64   (i_ld_elem64),
        .i_wide     (i_ld_wide),
        .o_byte_en  (ld_be),
        .o_all_ones (ld_all1),
        .o_all_zero (ld_all0)
    );

    ////////////////////////////////////////////////////////////////////////////
    // store queue of uncommitted stores, oldest at head
    logic [47:0]  stq_addr_reg  [mlsau_pkg::STQ_DEPTH];
    logic [255:0] stq_data_reg  [mlsau_pkg::STQ_DEPTH];
    logic [31:0]  stq_be_reg    [mlsau_pkg::STQ_DEPTH];
    logic [mlsau_pkg::STQ_DEPTH-1:0] stq_vld_reg;
    logic [mlsau_pkg::STQ_DEPTH-1:0] stq_known_reg;
    logic [mlsau_pkg::STQ_DEPTH-1:0] stq_all1_reg;
    logic [mlsau_pkg::STQ_IDX_BITS-1:0] stq_head_reg;
    logic [mlsau_pkg::STQ_IDX_BITS-1:0] stq_tail_reg;
    logic [7:0]   split_cnt_reg;
    logic         st_full;

    function automatic logic [31:0] span_be(input logic [47:0] a, input logic [31:0] be);
        // rotate element bytes to the low address bits of a 32-byte window
        span_be = (be << a[4:0]) | (be >> (6'd32 - {1'b0, a[4:0]}));
    endfunction : span_be

    function automatic logic crosses(input logic [47:0] a, input int bits);
        crosses = ({1'b0, a[mlsau_pkg::PAGE_BITS-1:0]} & ((13'h1 << bits) - 13'h1))
                  > ((13'h1 << bits) - 13'd32);
    endfunction : crosses

    assign st_full = &stq_vld_reg;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            stq_vld_reg   <= '0;
            stq_known_reg <= '0;
            stq_all1_reg  <= '0;
            stq_head_reg  <= '0;
            stq_tail_reg  <= '0;
        end else begin
            if (i_st_valid && !st_full) begin
                stq_vld_reg[stq_tail_reg]   <= 1'b1;
                stq_known_reg[stq_tail_reg] <= !i_st_masked || i_st_mask_known;
                stq_all1_reg[stq_tail_reg]  <= !i_st_masked || st_all1;
                stq_tail_reg <= stq_tail_reg + 2'h1;
            end
            // a mask arriving late resolves the youngest store's byte enables
            // only an unresolved entry takes the late mask; a resolved one keeps its own
            if (i_st_mask_known && !i_st_valid && stq_vld_reg[stq_tail_reg - 2'h1]
                && !stq_known_reg[stq_tail_reg - 2'h1]) begin
                stq_known_reg[stq_tail_reg - 2'h1] <= 1'b1;
                stq_all1_reg[stq_tail_reg - 2'h1]  <= st_all1;
            end
            if (o_st_write && split_cnt_reg == '0) begin
                stq_vld_reg[stq_head_reg] <= 1'b0;
                stq_head_reg <= stq_head_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_st_valid && !st_full) begin
            stq_addr_reg[stq_tail_reg] <= i_st_addr;
            stq_data_reg[stq_tail_reg] <= i_st_data;
            stq_be_reg[stq_tail_reg]   <= i_st_masked ? st_be : 32'hFFFFFFFF;
        end else if (i_st_mask_known && stq_vld_reg[stq_tail_reg - 2'h1]
                     && !stq_known_reg[stq_tail_reg - 2'h1]) begin
            stq_be_reg[stq_tail_reg - 2'h1] <= st_be;
        end
    end

    // cache write of head store; split page-crossing stores pay a long stall unless o_st_busy is set
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_st_write      <= 1'b0;
            o_st_write_addr <= '0;
            o_st_write_data <= '0;
            o_st_write_be   <= '0;
            split_cnt_reg   <= '0;
            o_st_busy       <= 1'b0;
        end else begin
            o_st_write <= 1'b0;
            o_st_busy  <= st_full;
            if (split_cnt_reg != '0) begin
                split_cnt_reg <= split_cnt_reg - 8'h1;
            end else if (i_st_commit && stq_vld_reg[stq_head_reg] && !o_st_write
                         && stq_known_reg[stq_head_reg]) begin
                if (crosses(stq_addr_reg[stq_head_reg], mlsau_pkg::PAGE_BITS)
                    && !o_st_busy) begin
                    split_cnt_reg <= 8'(mlsau_pkg::SPLIT_PG_CYC - 1);
                    o_st_busy     <= 1'b1;
                end
                o_st_write      <= 1'b1;
                o_st_write_addr <= stq_addr_reg[stq_head_reg];
                o_st_write_data <= stq_data_reg[stq_head_reg];
                o_st_write_be   <= stq_be_reg[stq_head_reg];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dependency and alias scan against every uncommitted store
    logic [31:0] ld_span;
    logic        dep_wait;
    logic        dep_fwd;
    logic [255:0] fwd_data;
    logic        alias_hit;

    assign ld_span = span_be(i_ld_addr, i_ld_masked ? ld_be : 32'hFFFFFFFF);

    always_comb begin
        dep_wait  = 1'b0;
        dep_fwd   = 1'b0;
        fwd_data  = '0;
        alias_hit = 1'b0;
        for (int i = 0; i < mlsau_pkg::STQ_DEPTH; i++) begin
            if (stq_vld_reg[i]) begin
                if (!stq_known_reg[i] && !i_disamb_clear) begin
                    dep_wait = 1'b1;
                end else if ((span_be(stq_addr_reg[i], stq_be_reg[i]) & ld_span) != '0) begin
                    if (stq_addr_reg[i][47:5] == i_ld_addr[47:5]) begin
                        if (stq_all1_reg[i] && stq_addr_reg[i] == i_ld_addr) begin
                            dep_fwd  = 1'b1;
                            fwd_data = stq_data_reg[i];
                        end else begin
                            dep_wait = 1'b1;
                        end
                    end else if (stq_addr_reg[i][mlsau_pkg::ALIAS_HI:mlsau_pkg::ALIAS_LO]
                                 == i_ld_addr[mlsau_pkg::ALIAS_HI:mlsau_pkg::ALIAS_LO]) begin
                        alias_hit = 1'b1;
                    end
                end
                // all-zero mask stores carry no enabled bytes, so never match
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    mlsau_pkg::mlsau_state_type state_reg;
    logic [7:0]   cnt_reg;
    logic [47:0]  ld_addr_reg;
    logic [31:0]  ld_be_reg;
    logic         ld_split_reg;
    logic         ld_illegal_reg;
    logic         ld_fault_pend_reg;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_reg         <= mlsau_pkg::MLSAU_IDLE;
            cnt_reg           <= '0;
            ld_addr_reg       <= '0;
            ld_be_reg         <= '0;
            ld_split_reg      <= 1'b0;
            ld_illegal_reg    <= 1'b0;
            ld_fault_pend_reg <= 1'b0;
            o_ld_done         <= 1'b0;
            o_ld_data         <= '0;
            o_ld_fault        <= 1'b0;
            o_ld_forwarded    <= 1'b0;
            o_ld_busy         <= 1'b0;
            o_alias_flag      <= 1'b0;
            o_fill_req        <= 1'b0;
            o_fill_addr       <= '0;
            o_alias_blocked_load_event <= '0;
        end else begin
            o_ld_done    <= 1'b0;
            o_alias_flag <= 1'b0;
            o_fill_req   <= 1'b0;
            case (state_reg)
                mlsau_pkg::MLSAU_IDLE: begin
                    o_ld_fault     <= 1'b0;
                    o_ld_forwarded <= 1'b0;
                    if (i_ld_valid) begin
                        o_ld_busy         <= 1'b1;
                        ld_addr_reg       <= i_ld_addr;
                        ld_be_reg         <= i_ld_masked ? ld_be : 32'hFFFFFFFF;
                        ld_split_reg      <= crosses(i_ld_addr, mlsau_pkg::LINE_BITS);
                        ld_illegal_reg    <= i_ld_illegal;
                        // fault only where an enabled byte hits the illegal part
                        ld_fault_pend_reg <= i_ld_illegal &&
                            ((i_ld_illegal_bytes & (i_ld_masked ? ld_be : 32'hFFFFFFFF)) != '0);
                        if (i_ld_illegal && i_ld_masked) begin
                            cnt_reg   <= 8'(mlsau_pkg::ASSIST_CYC - 1);
                            state_reg <= mlsau_pkg::MLSAU_ASSIST;
                        end else if (crosses(i_ld_addr, mlsau_pkg::PAGE_BITS)) begin
                            state_reg <= mlsau_pkg::MLSAU_RETIRE;
                        end else begin
                            state_reg <= mlsau_pkg::MLSAU_WAIT;
                        end
                    end
                end
                mlsau_pkg::MLSAU_ASSIST: begin
                    // assist runs even for all-zero masks
                    if (cnt_reg == '0) begin
                        state_reg <= mlsau_pkg::MLSAU_DONE;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h1;
                    end
                end
                mlsau_pkg::MLSAU_RETIRE: begin
                    if (i_ld_retire) begin
                        state_reg <= mlsau_pkg::MLSAU_WAIT;
                    end
                end
                mlsau_pkg::MLSAU_WAIT: begin
                    if (ld_illegal_reg) begin
                        state_reg <= mlsau_pkg::MLSAU_DONE;
                    end else if (alias_hit) begin
                        o_alias_flag <= 1'b1;
                        o_alias_blocked_load_event <= o_alias_blocked_load_event + 32'h1;
                        if (ld_split_reg) begin
                            cnt_reg <= '0; // stay until store commits
                        end else begin
                            cnt_reg   <= 8'(mlsau_pkg::ALIAS_PENALTY - 1);
                            state_reg <= mlsau_pkg::MLSAU_DELAY;
                        end
                    end else if (dep_fwd && !dep_wait) begin
                        for (int b = 0; b < mlsau_pkg::VEC_BYTES; b++) begin
                            o_ld_data[b*8 +: 8] <= ld_be_reg[b] ? fwd_data[b*8 +: 8]
                                                               : 8'h00;
                        end
                        o_ld_forwarded <= 1'b1;
                        o_ld_done      <= 1'b1;
                        o_ld_busy      <= 1'b0;
                        state_reg      <= mlsau_pkg::MLSAU_IDLE;
                    end else if (!dep_wait) begin
                        state_reg <= mlsau_pkg::MLSAU_MISS;
                    end
                end
                mlsau_pkg::MLSAU_DELAY: begin
                    if (cnt_reg == '0) begin
                        state_reg <= mlsau_pkg::MLSAU_MISS;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h1;
                    end
                end
                mlsau_pkg::MLSAU_MISS: begin
                    if (i_cache_hit || i_fill_done) begin
                        for (int b = 0; b < mlsau_pkg::VEC_BYTES; b++) begin
                            o_ld_data[b*8 +: 8] <= ld_be_reg[b] ? i_cache_data[b*8 +: 8]
                                                               : 8'h00;
                        end
                        o_ld_done <= 1'b1;
                        o_ld_busy <= 1'b0;
                        state_reg <= mlsau_pkg::MLSAU_IDLE;
                    end else begin
                        o_fill_req  <= 1'b1;
                        o_fill_addr <= {ld_addr_reg[47:mlsau_pkg::LINE_BITS],
                                        {mlsau_pkg::LINE_BITS{1'b0}}};
                    end
                end
                mlsau_pkg::MLSAU_DONE: begin
                    o_ld_fault <= ld_fault_pend_reg;
                    o_ld_data  <= '0;
                    o_ld_done  <= 1'b1;
                    o_ld_busy  <= 1'b0;
                    state_reg  <= mlsau_pkg::MLSAU_IDLE;
                end
                default: begin
                    state_reg <= mlsau_pkg::MLSAU_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_zero_mask_fault: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (state_reg == mlsau_pkg::MLSAU_DONE && !ld_fault_pend_reg) |=> !o_ld_fault)
        else $error("fault raised without an enabled illegal byte");
    chk_alias_penalty: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (state_reg == mlsau_pkg::MLSAU_WAIT && alias_hit && !ld_split_reg && !ld_illegal_reg)
        |=> (state_reg == mlsau_pkg::MLSAU_DELAY) [*5] ##1 state_reg == mlsau_pkg::MLSAU_MISS)
        else $error("alias penalty not five cycles");
    chk_alias_count: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_alias_flag |-> o_alias_blocked_load_event == $past(o_alias_blocked_load_event) + 32'h1)
        else $error("alias event not counted");
    chk_unknown_blocks: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (state_reg == mlsau_pkg::MLSAU_WAIT && (stq_vld_reg & ~stq_known_reg) != '0
         && !i_disamb_clear && !ld_illegal_reg) |=> !o_ld_done)
        else $error("load passed an unresolved masked store");
    chk_retire_wait: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (state_reg == mlsau_pkg::MLSAU_RETIRE && !i_ld_retire) |=> state_reg == mlsau_pkg::MLSAU_RETIRE)
        else $error("page-crossing load ran before retirement");
    chk_split_store: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $rose(split_cnt_reg != '0) |-> split_cnt_reg == 8'(mlsau_pkg::SPLIT_PG_CYC - 1))
        else $error("split page store stall wrong length");
    chk_fill_on_miss: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (state_reg == mlsau_pkg::MLSAU_MISS && !i_cache_hit && !i_fill_done) |=> o_fill_req)
        else $error("miss without fill request");
    chk_assist_len: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $rose(state_reg == mlsau_pkg::MLSAU_ASSIST) |-> ##[3:4] state_reg == mlsau_pkg::MLSAU_DONE)
        else $error("assist length wrong");
endmodule : mlsau_core

/* File: hdl/mlsau_mask_decode.sv */
/*
 mask decode for a conditional_vector_move: per-byte enables from element sign bits.
 assumes mask arrives in the same clock domain; purely combinational.
*/
`timescale 1ns/1ps
module mlsau_mask_decode (
    input  wire logic [255:0] i_mask,
    input  wire logic         i_elem64,
    input  wire logic         i_wide,
    output logic      [31:0]  o_byte_en,
    output logic              o_all_ones,
    output logic              o_all_zero
);
    logic [7:0] lane_en;

    // element enable is each element's top bit
    genvar g;
    generate
        for (g = 0; g < mlsau_pkg::LANES32; g = g + 1) begin : g_lane
            assign lane_en[g] = ((g >= 4) && !i_wide) ? 1'b0 :
                                i_elem64 ? i_mask[(g / 2) * 64 + 63] : i_mask[g * 32 + 31];
            assign o_byte_en[g * 4 +: 4] = {4{lane_en[g]}};
        end
    endgenerate

    assign o_all_ones = i_wide ? (&lane_en) : (&lane_en[3:0]);
    assign o_all_zero = ~|lane_en;
endmodule : mlsau_mask_decode

/* File: hdl/mlsau_pkg.sv */
/*
 package for the masked load/store alias unit: sizes, field positions, timing counts.
 assumes one core clock domain at 50 MHz.
*/
package mlsau_pkg;
    localparam int VEC_BITS        = 256;
    localparam int VEC_BYTES       = 32;
    localparam int ADDR_BITS       = 48;
    localparam int LANES32         = 8;
    localparam int STQ_DEPTH       = 4;
    localparam int STQ_IDX_BITS    = 2;
    localparam int ALIAS_LO        = 5;
    localparam int ALIAS_HI        = 11;
    localparam int PAGE_BITS       = 12;
    localparam int LINE_BITS       = 6;
    localparam int ALIAS_PENALTY   = 5;
    localparam int SPLIT_PG_CYC    = 150;
    localparam int ASSIST_CYC      = 4;
    localparam int CNT_BITS        = 8;
    localparam int EVT_BITS        = 32;

    typedef enum logic [2:0] {
        MLSAU_IDLE   = 3'b000,
        MLSAU_ASSIST = 3'b001,
        MLSAU_WAIT   = 3'b010,
        MLSAU_DELAY  = 3'b011,
        MLSAU_RETIRE = 3'b100,
        MLSAU_MISS   = 3'b101,
        MLSAU_DONE   = 3'b110
    } mlsau_state_type;
endpackage : mlsau_pkg

/* File: verification/mlsau_cache_model.sv */
/*
 cache-side partner model: hit answer, line fill after a request.
 assumes one core clock; the bench picks hit or miss behaviour.
*/
`timescale 1ns/1ps
module mlsau_cache_model #(
    parameter logic [255:0] LINE_PAT = {8{32'h5A5A_A5C3}}
) (
    input  wire logic         i_clock,
    input  wire logic         i_miss_mode,
    input  wire logic         i_fill_req,
    output logic              o_cache_hit,
    output logic [255:0]      o_cache_data,
    output logic              o_fill_done
);
    logic [1:0] wait_reg;
    logic       line_reg;
    initial begin
        wait_reg = 2'h0;
        line_reg = 1'b0;
        o_fill_done = 1'b0;
    end
    assign o_cache_hit  = ~i_miss_mode | line_reg;
    assign o_cache_data = LINE_PAT;
    // fill answered three cycles after the request, not at once
    always @(posedge i_clock) begin
        o_fill_done <= (wait_reg == 2'h1);
        // a held request must not restart a fill already under way
        wait_reg    <= (i_fill_req && wait_reg == 2'h0 && !o_fill_done) ? 2'h3 :
                       (wait_reg != 2'h0 ? wait_reg - 2'h1 : 2'h0);
        line_reg    <= i_fill_req ? 1'b0 : (o_fill_done ? 1'b1 : line_reg);
    end
endmodule : mlsau_cache_model

/* File: verification/tb.sv */
/*
 testbench for mlsau_core: masked loads, masked stores, 4k alias, miss fill.
 assumes the cache model above as far side; core side driven here.
*/
`timescale 1ns/1ps
module tb;
    localparam logic [255:0] PAT = {8{32'h5A5A_A5C3}};
    logic clk = 0, rst_n = 0, st_valid = 0, st_masked = 0, st_known = 1, st_e64 = 0;
    logic st_wide = 1, st_commit = 0, ld_valid = 0, ld_masked = 1, ld_e64 = 0, ld_wide = 1;
    logic ld_ill = 0, ld_retire = 0, dis_clr = 0, miss_mode = 0, hit, fdone, alias_seen;
    logic [47:0] st_addr = 48'h0, ld_addr = 48'h0, fa;
    logic [255:0] st_data = PAT, st_mask = '0, ld_mask = '0, cdata;
    logic [31:0] ld_ibytes = 32'h0;
    wire logic fill_req, st_wr, st_busy, ld_done, ld_fault, ld_fwd, ld_busy, alias_flag;
    wire logic [47:0] fill_addr, wr_addr;
    wire logic [255:0] wr_data, ld_data;
    wire logic [31:0] wr_be, ev;
    int bad_count = 0, cmp_count = 0, cyc = 0, lat = 0, plain_lat = 0;
    always #10 clk = ~clk;
    mlsau_cache_model #(.LINE_PAT(PAT)) i_mlsau_cache_model (.i_clock(clk),
        .i_miss_mode(miss_mode), .i_fill_req(fill_req), .o_cache_hit(hit),
        .o_cache_data(cdata), .o_fill_done(fdone));
    mlsau_core i_mlsau_core (.i_clock(clk), .i_rst_n(rst_n), .i_st_valid(st_valid),
        .i_st_addr(st_addr), .i_st_data(st_data), .i_st_mask(st_mask),
        .i_st_masked(st_masked), .i_st_mask_known(st_known), .i_st_elem64(st_e64),
        .i_st_wide(st_wide), .i_st_commit(st_commit), .i_ld_valid(ld_valid),
        .i_ld_addr(ld_addr), .i_ld_mask(ld_mask), .i_ld_masked(ld_masked),
        .i_ld_elem64(ld_e64), .i_ld_wide(ld_wide), .i_ld_illegal(ld_ill),
        .i_ld_illegal_bytes(ld_ibytes), .i_ld_retire(ld_retire),
        .i_disamb_clear(dis_clr), .i_cache_hit(hit), .i_cache_data(cdata),
        .i_fill_done(fdone), .o_fill_req(fill_req), .o_fill_addr(fill_addr),
        .o_st_write(st_wr), .o_st_write_addr(wr_addr), .o_st_write_data(wr_data),
        .o_st_write_be(wr_be), .o_st_busy(st_busy), .o_ld_done(ld_done),
        .o_ld_data(ld_data), .o_ld_fault(ld_fault), .o_ld_forwarded(ld_fwd),
        .o_ld_busy(ld_busy), .o_alias_flag(alias_flag), .o_alias_blocked_load_event(ev));
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////
    // one load, valid for one cycle, then waited on until done; notes alias pulse, fill address, latency
    task automatic do_load(input logic [47:0] a, input logic [255:0] m, input logic ill);
        @(posedge clk); #1;
        ld_valid = 1; ld_addr = a; ld_mask = m; ld_ill = ill; ld_ibytes = {32{ill}};
        @(posedge clk); #1;
        ld_valid = 0; alias_seen = 0; lat = 0;
        while (ld_done !== 1'b1 && lat < 400) begin
            if (alias_flag === 1'b1) alias_seen = 1;
            if (fill_req === 1'b1) fa = fill_addr;
            @(posedge clk); #1;
            lat++;
        end
        check(lat < 400, 1'b1);
    endtask : do_load
    task automatic do_store(input logic [47:0] a, input logic [255:0] m, input logic msk);
        @(posedge clk); #1;
        st_valid = 1; st_addr = a; st_mask = m; st_masked = msk;
        @(posedge clk); #1;
        st_valid = 0;
    endtask : do_store
    task automatic drain(output logic [31:0] be);
        int n;
        n = 0;
        st_commit = 1;
        while (st_wr !== 1'b1 && n < 400) begin
            @(posedge clk); #1;
            n++;
        end
        be = wr_be;
        check(wr_addr, st_addr);
        st_commit = 0;
    endtask : drain
    ////////////////////////////////////////////////////////////////////////////
    task automatic s_mask_load();
        logic [255:0] m, e;
        m = 256'h7FFF_FFFF; // low bits only: element 0 stays off
        e = '0;
        for (int i = 1; i < 8; i += 2) begin
            m[32*i+31] = 1'b1;
            e[32*i+:32] = PAT[32*i+:32];
        end
        do_load(48'h0000_0000_1000, m, 1'b0);
        plain_lat = lat;
        check(ld_data, e);
        check(ld_fault, 1'b0);
    endtask : s_mask_load
    task automatic s_zero_illegal();
        do_load(48'h0000_0000_2FF0, '0, 1'b1);
        check(ld_fault, 1'b0);
        check(ld_data, '0);
    endtask : s_zero_illegal
    task automatic s_store_be();
        logic [31:0] be;
        st_e64 = 1;
        do_store(48'h0000_0000_0100, {64'h0, 64'h8000_0000_0000_0000, 64'h0,
                 64'h8000_0000_0000_0000}, 1'b1);
        drain(be);
        check(be, 32'h00FF_00FF);
        st_e64 = 0;
    endtask : s_store_be
    task automatic s_alias();
        logic [31:0] ev0, be;
        ev0 = ev;
        do_store(48'h0000_0040_1020, '1, 1'b0);
        do_load(48'h0000_0040_0020, '1, 1'b0);
        check(alias_seen, 1'b1);
        check(ev, ev0 + 32'h1);
        check(lat >= plain_lat + 5, 1'b1);
        drain(be);
    endtask : s_alias
    task automatic s_forward();
        logic [31:0] be;
        do_store(48'h0000_0000_3000, '1, 1'b0);
        do_load(48'h0000_0000_3000, '1, 1'b0);
        check(ld_fwd, 1'b1);
        check(ld_data, PAT);
        drain(be);
    endtask : s_forward
    task automatic s_miss();
        miss_mode = 1;
        do_load(48'h0000_0123_4567, '1, 1'b0);
        check(fa, 48'h0000_0123_4540);
        check(ld_data, PAT);
        miss_mode = 0;
    endtask : s_miss
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1;
        s_mask_load();
        s_zero_illegal();
        s_store_be();
        s_alias();
        s_forward();
        s_miss();
        finish_test();
    end
endmodule : tb
